// *** opstack_unit.sv ***
// operand address generation and system/user stack sequencing
`timescale 1ns/10ps
`default_nettype none

// How it works
// - push lowers the stack pointer by one, then writes there.
// - pop reads at the stack pointer, then raises it by one.
// - call saves the program counter on the stack; return restores it.
// - interrupt saves program counter and flags; interrupt return restores both.
// - user stacks in the register file, pushed and popped up or down.
// - eight-bit stack pointer register sits at register location D9h.
// - register mode returns the named register or pair as operand.
// - indirect register mode uses register contents as operand address.
// - indirect and indexed accesses never reach the upper control area.
// - indexed register address is instruction base plus working register.
// - indexed memory address is register pair plus short or long offset.
// - only plain load indexes registers; program memory load indexes memory.
// - external memory load and its forms are refused.
// - direct mode gives a 16-bit address for jumps, calls and loads.
// - indirect address mode only for call, target read from program memory.
// - indirect address pointer is 8-bit, upper address bits zero.
// - relative mode adds signed displacement to next instruction address.
// - relative mode belongs to bit test, decrement, compare and relative jumps.
// - immediate mode takes a byte or word from the instruction.
// - short working address high bit picks pointer, joins five and three bits.
// - register address with working code nibble maps to a working register.

module opstack_unit
  import opstack_pkg::*;
(
  input wire logic I_CLOCK,          // core clock
  input wire logic I_RESETN,         // async reset, active low
  input wire req_t I_REQ,            // decoded request
  input wire logic [15:0] I_PC,      // next instruction address
  input wire logic [7:0] I_FLAGS,    // flags register
  input wire logic [7:0] I_WORKING_POINTER_ZERO, // working pointer zero
  input wire logic [7:0] I_WORKING_POINTER_ONE,  // working pointer one
  input wire logic [7:0] I_RF_RDATA, // register file read data
  input wire logic [7:0] I_PM_RDATA, // program memory read data
  input wire logic I_SFR_WE,         // direct register write strobe
  input wire logic [7:0] I_SFR_ADDR, // direct register address
  input wire logic [7:0] I_SFR_WDATA, // direct register write data
  output logic O_BUSY,               // request in progress
  output logic O_DONE,               // completion pulse
  output logic O_FAULT,              // request refused, with done
  output var rf_req_t O_RF,          // register file access
  output var pm_req_t O_PM,          // program memory read
  output logic [15:0] O_EA,          // effective address
  output logic O_EA_SET1,            // address may reach upper area
  output logic [15:0] O_OPERAND,     // operand or popped byte
  output logic O_PC_LOAD,            // program counter load pulse
  output logic [15:0] O_PC_NEXT,     // program counter value
  output logic O_FLAGS_LOAD,         // flags load pulse
  output logic [7:0] O_FLAGS_NEXT,   // flags value
  output logic [7:0] O_SP,           // stack pointer byte
  output logic [7:0] O_SFR_RDATA     // direct register read data
);

  // ---------------------------------------------
  // state
  // ---------------------------------------------
  state_t state_q, state_d;
  logic [1:0] cnt_q, cnt_d;
  logic [1:0] nrd_q, nrd_d;
  req_t req_q, req_d;
  logic [15:0] pc_q, pc_d;
  logic [7:0] fl_q, fl_d;
  logic fault_q, fault_d;
  logic [7:0] sp_q, sp_d;
  logic [7:0] byt_q [0:2];
  logic cap_q, cap_d;
  logic cap_pm_q, cap_pm_d;
  logic [1:0] tag_q, tag_d;
  rf_req_t rf_q, rf_d;
  pm_req_t pm_q, pm_d;
  logic [15:0] ea_q, ea_d;
  logic eas1_q, eas1_d;
  logic [15:0] opnd_q, opnd_d;
  logic [15:0] tgt_q, tgt_d;
  logic done_q, done_d;
  logic flt_q, flt_d;
  logic pcl_q, pcl_d;
  logic [15:0] pcn_q, pcn_d;
  logic fll_q, fll_d;
  logic [7:0] fln_q, fln_d;
  logic busy_q;
  logic [7:0] sfr_q;

  // ---------------------------------------------
  // request checks
  // ---------------------------------------------
  logic is_br, f_ext, f_xr, f_xm, f_ia, f_rel, chk_mode, fault_w;
  logic rd_none_in, rd_pair_in, stk_in, user_in;
  logic [1:0] nrd_in;

  assign is_br = (I_REQ.inst == I_BIT_TEST_JUMP_FALSE)
               | (I_REQ.inst == I_BIT_TEST_JUMP_TRUE)
               | (I_REQ.inst == I_DECREMENT_JUMP_NONZERO)
               | (I_REQ.inst == I_COMPARE_INCREMENT_JUMP_EQUAL)
               | (I_REQ.inst == I_COMPARE_INCREMENT_JUMP_UNEQUAL)
               | (I_REQ.inst == I_RELATIVE_JUMP);
  assign f_ext = (I_REQ.inst == I_EXTERNAL_MEMORY_LOAD);
  assign f_xr = (I_REQ.mode == M_IDX_REG) & (I_REQ.inst != I_PLAIN_LOAD);
  assign f_xm = ((I_REQ.mode == M_IDX_SHORT) | (I_REQ.mode == M_IDX_LONG))
              & (I_REQ.inst != I_PROGRAM_MEMORY_LOAD);
  assign f_ia = (I_REQ.mode == M_IND_ADDR) & (I_REQ.inst != I_CALL);
  assign f_rel = (I_REQ.mode == M_REL) & ~is_br;
  assign chk_mode = (I_REQ.op == OP_ADDR) | (I_REQ.op == OP_CALL);
  assign fault_w = f_ext | (chk_mode & (f_xr | f_xm | f_ia | f_rel));

  assign rd_none_in = (I_REQ.mode == M_DIRECT) | (I_REQ.mode == M_REL)
                    | (I_REQ.mode == M_IMM);
  assign rd_pair_in = (I_REQ.mode == M_IND_PAIR) | (I_REQ.mode == M_IDX_SHORT)
                    | (I_REQ.mode == M_IDX_LONG) | (I_REQ.mode == M_IND_ADDR)
                    | ((I_REQ.mode == M_REG) & I_REQ.wide);
  assign stk_in = ~chk_mode & (I_REQ.op <= OP_INTERRUPT_RETURN);
  assign user_in = (I_REQ.op >= OP_USER_PUSH_INCREMENTING);
  assign nrd_in = user_in ? RD_ONE
                : (stk_in | rd_none_in) ? RD_NONE
                : rd_pair_in ? RD_TWO : RD_ONE;

  // ---------------------------------------------
  // address arithmetic
  // ---------------------------------------------
  logic [7:0] wa;
  logic rd_pm;
  logic [15:0] pm_base, pair_w, sa_w, sb_w, ea_w, opnd_w;
  logic [7:0] idx_sum;

  wreg_map u_wreg (
    .i_addr (req_q.field_a),
    .i_short (req_q.short_wreg),
    .i_ptr0 (I_WORKING_POINTER_ZERO),
    .i_ptr1 (I_WORKING_POINTER_ONE),
    .o_addr (wa)
  );

  assign rd_pm = (req_q.mode == M_IND_ADDR);
  assign pm_base = {PM_PAGE, req_q.field_a};
  assign pair_w = {byt_q[BUF_HI], byt_q[BUF_LO]};
  assign sa_w = {{8{req_q.field_a[7]}}, req_q.field_a};
  assign sb_w = {{8{req_q.field_b[7]}}, req_q.field_b[7:0]};
  assign idx_sum = req_q.field_b[7:0] + byt_q[BUF_LO];

  always_comb begin
    unique case (req_q.mode)
      M_REG: ea_w = {8'h00, wa};
      M_IND_REG: ea_w = {8'h00, byt_q[BUF_LO]};
      M_IND_PAIR: ea_w = pair_w;
      M_IDX_REG: ea_w = {8'h00, idx_sum};
      M_IDX_SHORT: ea_w = pair_w + sb_w;
      M_IDX_LONG: ea_w = pair_w + req_q.field_b;
      M_DIRECT: ea_w = req_q.field_b;
      M_IND_ADDR: ea_w = pair_w;
      M_REL: ea_w = pc_q + sa_w;
      M_IMM: ea_w = 16'h0000;
      default: ea_w = 16'h0000;
    endcase
  end

  assign opnd_w = (req_q.mode == M_IMM)
                ? (req_q.wide ? req_q.field_b : {8'h00, req_q.field_b[7:0]})
                : (req_q.mode == M_REG)
                ? (req_q.wide ? pair_w : {8'h00, byt_q[BUF_LO]})
                : 16'h0000;

  // ---------------------------------------------
  // stack decode
  // ---------------------------------------------
  logic [1:0] nstk_w, pop_idx;
  logic push_w, user_w, upush_w, uinc_w, sfr_sp_wr;
  logic [7:0] sp_dec, sp_inc, push_byte, uptr_next;

  assign nstk_w = ((req_q.op == OP_PUSH) | (req_q.op == OP_POP)) ? STK_ONE
                : ((req_q.op == OP_CALL) | (req_q.op == OP_RET)) ? STK_PC
                : ((req_q.op == OP_INTR) | (req_q.op == OP_INTERRUPT_RETURN)) ? STK_CTX
                : STK_NONE;
  assign push_w = (req_q.op == OP_PUSH) | (req_q.op == OP_CALL) | (req_q.op == OP_INTR);
  assign user_w = (req_q.op >= OP_USER_PUSH_INCREMENTING);
  assign upush_w = (req_q.op == OP_USER_PUSH_INCREMENTING)
                 | (req_q.op == OP_USER_PUSH_DECREMENTING);
  assign uinc_w = (req_q.op == OP_USER_PUSH_INCREMENTING)
                | (req_q.op == OP_USER_POP_INCREMENTING);
  assign sp_dec = sp_q - STEP;
  assign sp_inc = sp_q + STEP;
  assign push_byte = (cnt_q == 2'h0)
                   ? ((req_q.op == OP_PUSH) ? req_q.data : pc_q[7:0])
                   : (cnt_q == 2'h1) ? pc_q[15:8] : fl_q;
  assign pop_idx = nstk_w - 2'h1 - cnt_q;
  assign uptr_next = uinc_w ? byt_q[BUF_LO] + STEP : byt_q[BUF_LO] - STEP;
  assign sfr_sp_wr = I_SFR_WE & (I_SFR_ADDR == SP_ADDR);

  // ---------------------------------------------
  // sequencer
  // ---------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    nrd_d = nrd_q;
    req_d = req_q;
    pc_d = pc_q;
    fl_d = fl_q;
    fault_d = fault_q;
    // stack traffic overrides a software write in the same cycle
    sp_d = sfr_sp_wr ? I_SFR_WDATA : sp_q;
    rf_d = '0;
    pm_d = '0;
    cap_d = 1'b0;
    cap_pm_d = 1'b0;
    tag_d = BUF_LO;
    ea_d = ea_q;
    eas1_d = eas1_q;
    opnd_d = opnd_q;
    tgt_d = tgt_q;
    done_d = 1'b0;
    flt_d = 1'b0;
    pcl_d = 1'b0;
    pcn_d = pcn_q;
    fll_d = 1'b0;
    fln_d = fln_q;
    unique case (state_q)
      ST_IDLE: begin
        if (I_REQ.valid) begin
          req_d = I_REQ;
          pc_d = I_PC;
          fl_d = I_FLAGS;
          fault_d = fault_w;
          nrd_d = nrd_in;
          cnt_d = 2'h0;
          if (fault_w) begin
            state_d = ST_FIN;
          end else if (nrd_in != RD_NONE) begin
            state_d = ST_RD;
          end else begin
            state_d = ST_CALC;
          end
        end
      end
      ST_RD: begin
        cap_d = 1'b1;
        cap_pm_d = rd_pm;
        tag_d = ((nrd_q == RD_TWO) && (cnt_q == 2'h0)) ? BUF_HI : BUF_LO;
        if (rd_pm) begin
          pm_d.re = 1'b1;
          pm_d.addr = pm_base + {14'h0000, cnt_q};
        end else begin
          // pointer and index registers are named directly
          rf_d.re = 1'b1;
          rf_d.set1 = 1'b1;
          rf_d.addr = wa + {6'h00, cnt_q};
        end
        cnt_d = cnt_q + 2'h1;
        if (cnt_q == nrd_q - 2'h1) begin
          state_d = ST_RDW;
        end
      end
      ST_RDW: begin
        state_d = ST_CALC;
      end
      ST_CALC: begin
        cnt_d = 2'h0;
        if ((req_q.op == OP_ADDR) || (req_q.op == OP_CALL)) begin
          ea_d = ea_w;
          opnd_d = opnd_w;
          tgt_d = ea_w;
          // only register mode access reaches upper area
          eas1_d = (req_q.mode == M_REG);
        end
        if (nstk_w != STK_NONE) begin
          state_d = ST_STK;
        end else if (user_w) begin
          state_d = ST_USR;
        end else begin
          state_d = ST_FIN;
        end
      end
      ST_STK: begin
        if (push_w) begin
          sp_d = sp_dec;
          rf_d.we = 1'b1;
          rf_d.addr = sp_dec;
          rf_d.wdata = push_byte;
        end else begin
          sp_d = sp_inc;
          rf_d.re = 1'b1;
          rf_d.addr = sp_q;
          cap_d = 1'b1;
          tag_d = pop_idx;
        end
        cnt_d = cnt_q + 2'h1;
        if (cnt_q == nstk_w - 2'h1) begin
          state_d = push_w ? ST_FIN : ST_STW;
        end
      end
      ST_STW: begin
        state_d = ST_FIN;
      end
      ST_USR: begin
        if (cnt_q == 2'h0) begin
          if (upush_w) begin
            rf_d.we = 1'b1;
            rf_d.addr = uptr_next;
            rf_d.wdata = req_q.data;
          end else begin
            rf_d.re = 1'b1;
            rf_d.addr = byt_q[BUF_LO];
            cap_d = 1'b1;
            tag_d = BUF_HI;
          end
          cnt_d = 2'h1;
        end else begin
          rf_d.we = 1'b1;
          rf_d.set1 = 1'b1;
          rf_d.addr = wa;
          rf_d.wdata = uptr_next;
          state_d = ST_FIN;
        end
      end
      ST_FIN: begin
        done_d = 1'b1;
        flt_d = fault_q;
        state_d = ST_IDLE;
        if (!fault_q) begin
          if ((req_q.op == OP_CALL) || ((req_q.op == OP_ADDR)
              && (req_q.inst == I_ABSOLUTE_JUMP) && (req_q.mode == M_DIRECT))) begin
            pcl_d = 1'b1;
            pcn_d = tgt_q;
          end
          if ((req_q.op == OP_RET) || (req_q.op == OP_INTERRUPT_RETURN)) begin
            pcl_d = 1'b1;
            pcn_d = pair_w;
          end
          if (req_q.op == OP_INTERRUPT_RETURN) begin
            fll_d = 1'b1;
            fln_d = byt_q[BUF_FL];
          end
          if (req_q.op == OP_POP) begin
            opnd_d = {8'h00, byt_q[BUF_LO]};
          end
          if (user_w && !upush_w) begin
            opnd_d = {8'h00, byt_q[BUF_HI]};
          end
        end
      end
    endcase
  end

  // ---------------------------------------------
  // registers
  // ---------------------------------------------
  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      state_q <= ST_IDLE;
      cnt_q <= 2'h0;
      nrd_q <= RD_NONE;
      req_q <= '0;
      pc_q <= 16'h0000;
      fl_q <= 8'h00;
      fault_q <= 1'b0;
      sp_q <= SP_RESET;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      nrd_q <= nrd_d;
      req_q <= req_d;
      pc_q <= pc_d;
      fl_q <= fl_d;
      fault_q <= fault_d;
      sp_q <= sp_d;
    end
  end

  // read data lands one cycle after its strobe
  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      for (int i = 0; i < 3; i++) begin
        byt_q[i] <= 8'h00;
      end
      cap_q <= 1'b0;
      cap_pm_q <= 1'b0;
      tag_q <= BUF_LO;
    end else begin
      if (cap_q) begin
        byt_q[tag_q] <= cap_pm_q ? I_PM_RDATA : I_RF_RDATA;
      end
      cap_q <= cap_d;
      cap_pm_q <= cap_pm_d;
      tag_q <= tag_d;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rf_q <= '0;
      pm_q <= '0;
      ea_q <= 16'h0000;
      eas1_q <= 1'b0;
      opnd_q <= 16'h0000;
      tgt_q <= 16'h0000;
      busy_q <= 1'b0;
      sfr_q <= 8'h00;
    end else begin
      rf_q <= rf_d;
      pm_q <= pm_d;
      ea_q <= ea_d;
      eas1_q <= eas1_d;
      opnd_q <= opnd_d;
      tgt_q <= tgt_d;
      busy_q <= (state_d != ST_IDLE);
      sfr_q <= (I_SFR_ADDR == SP_ADDR) ? sp_q : 8'h00;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      done_q <= 1'b0;
      flt_q <= 1'b0;
      pcl_q <= 1'b0;
      pcn_q <= 16'h0000;
      fll_q <= 1'b0;
      fln_q <= 8'h00;
    end else begin
      done_q <= done_d;
      flt_q <= flt_d;
      pcl_q <= pcl_d;
      pcn_q <= pcn_d;
      fll_q <= fll_d;
      fln_q <= fln_d;
    end
  end

  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  assign O_BUSY = busy_q;
  assign O_DONE = done_q;
  assign O_FAULT = flt_q;
  assign O_RF = rf_q;
  assign O_PM = pm_q;
  assign O_EA = ea_q;
  assign O_EA_SET1 = eas1_q;
  assign O_OPERAND = opnd_q;
  assign O_PC_LOAD = pcl_q;
  assign O_PC_NEXT = pcn_q;
  assign O_FLAGS_LOAD = fll_q;
  assign O_FLAGS_NEXT = fln_q;
  assign O_SP = sp_q;
  assign O_SFR_RDATA = sfr_q;

endmodule

`default_nettype wire

// *** opstack_pkg.sv ***
// types and constants shared by the operand address and stack unit
package opstack_pkg;

  // ---------------------------------------------
  // register map, reset values, arithmetic steps
  // ---------------------------------------------
  localparam logic [7:0] SP_ADDR = 8'hD9;
  // pointer powers up undefined; zero keeps simulation deterministic
  localparam logic [7:0] SP_RESET = 8'h00;
  localparam logic [3:0] WREG_CODE = 4'hC;
  localparam logic [7:0] PM_PAGE = 8'h00;
  localparam logic [7:0] STEP = 8'h01;

  // ---------------------------------------------
  // byte slots and transfer counts
  // ---------------------------------------------
  localparam logic [1:0] BUF_LO = 2'h0;
  localparam logic [1:0] BUF_HI = 2'h1;
  localparam logic [1:0] BUF_FL = 2'h2;
  localparam logic [1:0] RD_NONE = 2'h0;
  localparam logic [1:0] RD_ONE = 2'h1;
  localparam logic [1:0] RD_TWO = 2'h2;
  localparam logic [1:0] STK_NONE = 2'h0;
  localparam logic [1:0] STK_ONE = 2'h1;
  localparam logic [1:0] STK_PC = 2'h2;
  localparam logic [1:0] STK_CTX = 2'h3;

  // ---------------------------------------------
  // operations, modes, instruction classes
  // ---------------------------------------------
  typedef enum logic [3:0] {
    OP_ADDR = 4'h0,
    OP_PUSH = 4'h1,
    OP_POP = 4'h2,
    OP_CALL = 4'h3,
    OP_RET = 4'h4,
    OP_INTR = 4'h5,
    OP_INTERRUPT_RETURN = 4'h6,
    OP_USER_PUSH_INCREMENTING = 4'h7,
    OP_USER_PUSH_DECREMENTING = 4'h8,
    OP_USER_POP_INCREMENTING = 4'h9,
    OP_USER_POP_DECREMENTING = 4'hA
  } op_t;

  typedef enum logic [3:0] {
    M_REG = 4'h0,
    M_IND_REG = 4'h1,
    M_IND_PAIR = 4'h2,
    M_IDX_REG = 4'h3,
    M_IDX_SHORT = 4'h4,
    M_IDX_LONG = 4'h5,
    M_DIRECT = 4'h6,
    M_IND_ADDR = 4'h7,
    M_REL = 4'h8,
    M_IMM = 4'h9
  } mode_t;

  typedef enum logic [3:0] {
    I_OTHER = 4'h0,
    I_PLAIN_LOAD = 4'h1,
    I_PROGRAM_MEMORY_LOAD = 4'h2,
    I_EXTERNAL_MEMORY_LOAD = 4'h3,
    I_ABSOLUTE_JUMP = 4'h4,
    I_CALL = 4'h5,
    I_BIT_TEST_JUMP_FALSE = 4'h6,
    I_BIT_TEST_JUMP_TRUE = 4'h7,
    I_DECREMENT_JUMP_NONZERO = 4'h8,
    I_COMPARE_INCREMENT_JUMP_EQUAL = 4'h9,
    I_COMPARE_INCREMENT_JUMP_UNEQUAL = 4'hA,
    I_RELATIVE_JUMP = 4'hB
  } inst_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RD = 3'h1,
    ST_RDW = 3'h2,
    ST_CALC = 3'h3,
    ST_STK = 3'h4,
    ST_STW = 3'h5,
    ST_USR = 3'h6,
    ST_FIN = 3'h7
  } state_t;

  // ---------------------------------------------
  // carriers
  // ---------------------------------------------
  typedef struct packed {
    logic valid;
    op_t op;
    mode_t mode;
    inst_t inst;
    logic wide;
    logic short_wreg;
    logic [7:0] field_a;
    logic [15:0] field_b;
    logic [7:0] data;
  } req_t;

  typedef struct packed {
    logic re;
    logic we;
    logic set1;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rf_req_t;

  typedef struct packed {
    logic re;
    logic [15:0] addr;
  } pm_req_t;

endpackage

// *** wreg_map.sv ***
// working register address resolver
`timescale 1ns/10ps
`default_nettype none

module wreg_map
  import opstack_pkg::*;
(
  input wire logic [7:0] i_addr, // register address field
  input wire logic i_short,      // field is a 4-bit working address
  input wire logic [7:0] i_ptr0, // working pointer zero
  input wire logic [7:0] i_ptr1, // working pointer one
  output logic [7:0] o_addr      // full register file address
);

  logic is_wreg;
  logic [7:0] ptr;

  assign is_wreg = i_short | (i_addr[7:4] == WREG_CODE);
  assign ptr = i_addr[3] ? i_ptr1 : i_ptr0;
  assign o_addr = is_wreg ? {ptr[7:3], i_addr[2:0]} : i_addr;

endmodule

`default_nettype wire

// *** opstack_assertions.sv ***
// concurrent checks on the operand address and stack unit ports
`timescale 1ns/10ps
`default_nettype none
module opstack_assertions
  import opstack_pkg::*;
(
  input wire logic I_CLOCK, // clock
  input wire logic I_RESETN, // reset
  input wire req_t I_REQ, // request
  input wire logic I_SFR_WE, // sfr write
  input wire logic [7:0] I_SFR_ADDR, // sfr address
  input wire logic [7:0] I_SFR_WDATA, // sfr data
  input wire logic O_BUSY, // busy
  input wire logic O_DONE, // done
  input wire logic O_FAULT, // refused
  input wire rf_req_t O_RF, // rf access
  input wire pm_req_t O_PM, // pm access
  input wire logic [15:0] O_EA, // address
  input wire logic O_PC_LOAD, // pc load
  input wire logic [15:0] O_PC_NEXT, // pc value
  input wire logic [7:0] O_SP, // stack pointer
  input wire logic [7:0] O_SFR_RDATA // sfr read
);
  // ------------------------------
  // accepted request bookkeeping
  // ------------------------------
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RESETN);
  wire logic take = I_REQ.valid && !O_BUSY;
  logic [7:0] ptr_q;
  logic ia_q;
  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ptr_q <= 8'h00;
      ia_q <= 1'b0;
    end else if (take) begin
      ptr_q <= I_REQ.field_a;
      ia_q <= I_REQ.mode == M_IND_ADDR;
    end
  end
  sequence quiet_s;
    !O_RF.re && !O_RF.we && !O_PM.re && !O_PC_LOAD;
  endsequence
  sequence call_saves_s;
    O_RF.we && O_RF.addr == $past(O_SP, 3) - 8'h01 ##1
    O_RF.we && O_RF.addr == $past(O_SP, 4) - 8'h02;
  endsequence
  push_predec_a:
  assert property (take && I_REQ.op == OP_PUSH |-> ##3 O_RF.we && !O_RF.set1 &&
    O_RF.addr == $past(O_SP, 3) - 8'h01 && O_SP == O_RF.addr) else $error("push address");
  pop_postinc_a:
  assert property (take && I_REQ.op == OP_POP |-> ##3 O_RF.re &&
    O_RF.addr == $past(O_SP, 3) && O_SP == O_RF.addr + 8'h01) else $error("pop address");
  ext_refuse_a:
  assert property (take && I_REQ.inst == I_EXTERNAL_MEMORY_LOAD |-> ##1 quiet_s ##1
    (O_DONE && O_FAULT && !O_RF.we && !O_PM.re)) else $error("external load taken");
  sfr_write_a:
  assert property (I_SFR_WE && I_SFR_ADDR == SP_ADDR && !O_BUSY && !I_REQ.valid
    |=> O_SP == $past(I_SFR_WDATA)) else $error("pointer write lost");
  sfr_read_a:
  assert property (!O_BUSY && !I_SFR_WE |=> O_SFR_RDATA ==
    ($past(I_SFR_ADDR) == SP_ADDR ? $past(O_SP) : 8'h00)) else $error("pointer read");
  call_direct_a:
  assert property (take && I_REQ.op == OP_CALL && I_REQ.mode == M_DIRECT |-> ##3
    call_saves_s ##1 (O_DONE && O_PC_LOAD && O_PC_NEXT == $past(I_REQ.field_b, 5)))
    else $error("direct call");
  direct_jump_a:
  assert property (take && I_REQ.op == OP_ADDR && I_REQ.mode == M_DIRECT &&
    I_REQ.inst == I_ABSOLUTE_JUMP |-> ##3 O_DONE && !O_FAULT && O_PC_LOAD &&
    O_EA == $past(I_REQ.field_b, 3)) else $error("direct jump");
  page_zero_a:
  assert property (O_PM.re && ia_q |-> O_PM.addr == {PM_PAGE, ptr_q} ||
    O_PM.addr == {PM_PAGE, ptr_q + 8'h01}) else $error("vector off page zero");
endmodule
bind opstack_unit opstack_assertions u_opstack_assertions (.I_CLOCK, .I_RESETN, .I_REQ,
  .I_SFR_WE, .I_SFR_ADDR, .I_SFR_WDATA, .O_BUSY, .O_DONE, .O_FAULT, .O_RF, .O_PM, .O_EA,
  .O_PC_LOAD, .O_PC_NEXT, .O_SP, .O_SFR_RDATA);
`default_nettype wire

// *** test_opstack_unit.sv ***
// self-checking bench for the operand address and stack unit
`timescale 1ns/10ps
`default_nettype none
module test_opstack_unit
  import opstack_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  req_t req = '0;
  logic [15:0] pc = '0;
  logic [7:0] flags = '0, sfr_addr = '0, sfr_wdata = '0, sp, sfr_rdata, fl_next;
  logic sfr_we = 1'b0, busy, done, fault, ea_set1, pc_load, fl_load, last_fault;
  logic [15:0] ea, operand, pc_next, x;
  rf_req_t rf;
  pm_req_t pm;
  logic [7:0] mem [256];
  int error_cnt = 0, checks_done = 0, cycles = 0;
  // register file and program memory answer in the strobe cycle
  wire logic [7:0] rf_rdata = mem[rf.addr];
  wire logic [7:0] pm_rdata = pm.addr[7:0] ^ pm.addr[15:8] ^ 8'h5A;
  opstack_unit u_opstack_unit (.I_CLOCK(clk), .I_RESETN(rst_n), .I_REQ(req), .I_PC(pc),
    .I_FLAGS(flags), .I_WORKING_POINTER_ZERO(8'h70), .I_WORKING_POINTER_ONE(8'hA8),
    .I_RF_RDATA(rf_rdata), .I_PM_RDATA(pm_rdata), .I_SFR_WE(sfr_we), .I_SFR_ADDR(sfr_addr),
    .I_SFR_WDATA(sfr_wdata), .O_BUSY(busy), .O_DONE(done), .O_FAULT(fault), .O_RF(rf),
    .O_PM(pm), .O_EA(ea), .O_EA_SET1(ea_set1), .O_OPERAND(operand), .O_PC_LOAD(pc_load),
    .O_PC_NEXT(pc_next), .O_FLAGS_LOAD(fl_load), .O_FLAGS_NEXT(fl_next), .O_SP(sp),
    .O_SFR_RDATA(sfr_rdata));
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    if (rf.we) mem[rf.addr] <= rf.wdata;
    if (++cycles == 5000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic go(input op_t op, input mode_t m, input inst_t i, input logic [7:0] fa,
    input logic [15:0] fb, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{1'b1, op, m, i, m == M_IMM, 1'b0, fa, fb, d};
    @(posedge clk);
    req.valid <= 1'b0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 12);
    last_fault = fault;
    if (n >= 12) chk("done", 0, 1);
  endtask
  task automatic sfr(input logic we, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_we <= we;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge clk);
    sfr_we <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic finish_test;
    if (error_cnt == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h3C;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk("sp reset", sp, SP_RESET);
    sfr(1, SP_ADDR, 8'hFF);
    chk("sp read", sfr_rdata, 8'hFF);
    sfr(0, 8'hD8, 8'h00);
    chk("unmapped", sfr_rdata, 0);
    for (int k = 0; k < 3; k++) go(OP_PUSH, M_REG, I_OTHER, 0, 0, 8'hA1 + 8'(k));
    for (int k = 0; k < 3; k++) chk("pushed", mem[8'hFE - k], 8'hA1 + 8'(k));
    for (int k = 0; k < 3; k++) begin
      go(OP_POP, M_REG, I_OTHER, 0, 0, 0);
      chk("popped", operand, 8'hA3 - 8'(k));
    end
    sfr(1, SP_ADDR, 8'h00);
    go(OP_PUSH, M_REG, I_OTHER, 0, 0, 8'h5E);
    chk("wrap", {sp, mem[255]}, 16'hFF5E);
    sfr(1, SP_ADDR, 8'hF0);
    pc <= 16'h1234;
    go(OP_CALL, M_DIRECT, I_CALL, 0, 16'h4567, 0);
    chk("call", pc_next, 16'h4567);
    chk("saved pc", {mem[8'hEE], mem[8'hEF]}, 16'h1234);
    go(OP_RET, M_REG, I_OTHER, 0, 0, 0);
    chk("ret", {pc_load, pc_next}, 17'h1_1234);
    pc <= 16'hABCD;
    flags <= 8'h5A;
    go(OP_INTR, M_REG, I_OTHER, 0, 0, 0);
    chk("ctx", {mem[8'hEE], mem[8'hEF]}, 16'hABCD);
    chk("flags", mem[8'hED], 8'h5A);
    go(OP_INTERRUPT_RETURN, M_REG, I_OTHER, 0, 0, 0);
    chk("interrupt_return", {fl_load, fl_next, pc_next[7:0], sp}, 25'h15A_CDF0);
    go(OP_ADDR, M_DIRECT, I_EXTERNAL_MEMORY_LOAD, 0, 0, 0);
    chk("ext", last_fault, 1);
    go(OP_ADDR, M_IDX_REG, I_PROGRAM_MEMORY_LOAD, 0, 0, 0);
    chk("idx reg", last_fault, 1);
    go(OP_CALL, M_IND_ADDR, I_ABSOLUTE_JUMP, 0, 0, 0);
    chk("ind jump", last_fault, 1);
    pc <= 16'h0100;
    for (int k = 0; k < 6; k++) begin
      x = 16'h0100 + {{8{k != 0}}, 8'h7F + 8'(k)};
      go(OP_ADDR, M_REL, inst_t'(4'h6 + 4'(k)), 8'h7F + 8'(k), 0, 0);
      chk("rel", {last_fault, ea}, {1'b0, x});
    end
    go(OP_ADDR, M_REG, I_PLAIN_LOAD, 8'hC9, 0, 0);
    chk("wreg", {ea_set1, ea, operand}, {17'h1_00A9, 16'h0095});
    go(OP_ADDR, M_IND_REG, I_PLAIN_LOAD, 8'h20, 0, 0);
    chk("ind reg", {ea_set1, ea}, 17'h0_001C);
    go(OP_ADDR, M_IDX_REG, I_PLAIN_LOAD, 8'hC2, 16'h0030, 0);
    chk("idx", ea, 16'h007E);
    go(OP_ADDR, M_IDX_SHORT, I_PROGRAM_MEMORY_LOAD, 8'h40, 16'h00FE, 0);
    chk("short idx", ea, 16'h7C7B);
    go(OP_ADDR, M_IDX_LONG, I_PROGRAM_MEMORY_LOAD, 8'h40, 16'h1000, 0);
    chk("long idx", ea, 16'h8C7D);
    go(OP_ADDR, M_IND_PAIR, I_PROGRAM_MEMORY_LOAD, 8'h40, 0, 0);
    chk("ind pair", {ea_set1, ea}, 17'h0_7C7D);
    go(OP_ADDR, M_DIRECT, I_ABSOLUTE_JUMP, 0, 16'hBEEF, 0);
    chk("jump", {pc_load, pc_next, ea}, 33'h1_BEEF_BEEF);
    go(OP_CALL, M_IND_ADDR, I_CALL, 8'h10, 0, 0);
    chk("vector", pc_next, 16'h4A4B);
    go(OP_ADDR, M_IMM, I_PLAIN_LOAD, 0, 16'hAA55, 0);
    chk("imm", operand, 16'hAA55);
    go(OP_USER_PUSH_INCREMENTING, M_REG, I_OTHER, 8'h50, 0, 8'hE7);
    chk("upush", {mem[8'h50], mem[8'h6D]}, 16'h6DE7);
    go(OP_USER_POP_DECREMENTING, M_REG, I_OTHER, 8'h50, 0, 0);
    chk("upop", {mem[8'h50], operand[7:0]}, 16'h6CE7);
    finish_test();
  end
endmodule
`default_nettype wire
